// ===== hdl/ees_defs.svh
// constants for the serial eeprom slave and its bus master
`ifndef EES_DEFS_SVH
`define EES_DEFS_SVH
`define EES_DEV_CODE      4'hA
`define EES_MEM_BYTES     512
`define EES_ADDR_W        9
`define EES_PAGE_BYTES    8
`define EES_FILTER_NS     50
`define EES_CLK_NS        25
`define EES_FILTER_CYC    ((`EES_FILTER_NS + `EES_CLK_NS - 1) / `EES_CLK_NS)
`define EES_TWC_CYC       200
`define EES_SCL_HALF_CYC  4
`endif

// ===== hdl/ees_pkg.sv
// types shared by both ends of the serial eeprom link
`default_nettype none
package ees_pkg;
	typedef enum logic [3:0] {
		ES_IDLE  = 4'h0,
		ES_DEV   = 4'h1,
		ES_AHI   = 4'h3,
		ES_ALO   = 4'h2,
		ES_WDAT  = 4'h6,
		ES_RDAT  = 4'h7,
		ES_RACK  = 4'h5,
		ES_WAIT  = 4'h4,
		ES_BUSY  = 4'hC
	} ees_state_e;
	typedef enum logic [3:0] {
		MS_IDLE  = 4'h0,
		MS_START = 4'h1,
		MS_BIT   = 4'h3,
		MS_ACK   = 4'h2,
		MS_STOP  = 4'h6,
		MS_DONE  = 4'h7
	} ees_mstate_e;
	typedef enum logic [1:0] {
		CMD_WRITE = 2'h0,
		CMD_READ  = 2'h1,
		CMD_STOP  = 2'h2
	} ees_cmd_e;
endpackage
`default_nettype wire

// ===== hdl/ees_if.sv
// two-wire link between the eeprom slave and its master
`default_nettype none
interface ees_if;
	logic scl_o;
	logic scl_oe;
	logic sda_m_oe;
	logic sda_s_oe;
	logic scl;
	logic sda;
	// open drain: either sda enable pulls low; scl is pulled low only when scl_oe is set with scl_o low
	assign scl = !(scl_oe && !scl_o);
	assign sda = !(sda_m_oe || sda_s_oe);
	modport slave (input scl, input sda, output sda_s_oe);
	modport master (input scl, input sda, output scl_o, output scl_oe,
		output sda_m_oe);
endinterface
`default_nettype wire

// ===== hdl/ees_fifo.sv
// valid/ready fifo used on the slave write path
`default_nettype none
module ees_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rstn,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("depth must be a power of two");
	end
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wp_r;
	logic [AW:0]      rp_r;
	wire              full  = (wp_r ^ rp_r) == {1'b1, {AW{1'b0}}};
	wire              empty = wp_r == rp_r;
	assign in_ready  = !full;
	assign out_valid = !empty;
	assign out_data  = mem[rp_r[AW-1:0]];
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			wp_r <= '0;
			rp_r <= '0;
		end else begin
			if (in_valid && !full)
				wp_r <= wp_r + 1'b1;
			if (out_ready && !empty)
				rp_r <= rp_r + 1'b1;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (in_valid && !full)
			mem[wp_r[AW-1:0]] <= in_data;
	end
endmodule
`default_nettype wire

// ===== hdl/ees_slave.sv
// serial eeprom slave: protocol engine, memory array and write cycle
`include "ees_defs.svh"
`default_nettype none
module ees_slave #(
	parameter int FILT_CYC = `EES_FILTER_CYC,
	parameter int TWC_CYC  = `EES_TWC_CYC
) (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rstn,
	// strap for the low slave address bits
	input  wire logic [2:0] slave_address_reference,
	// status
	output logic            busy,
	// link
	ees_if.slave            bus
);
	// the write cycle must outlast draining a full page queue
	if (FILT_CYC < 1 || FILT_CYC > 15 || TWC_CYC < `EES_PAGE_BYTES + 2 ||
		TWC_CYC > 65535) begin : g_bad_timing
		$error("bad slave timing parameters");
	end
	typedef struct packed {
		logic [1:0]         scl_sy;
		logic [1:0]         sda_sy;
		logic [3:0]         scl_cnt;
		logic [3:0]         sda_cnt;
		logic               scl_f;
		logic               sda_f;
		ees_pkg::ees_state_e st;
		logic [3:0]         bitn;
		logic [7:0]         sh;
		logic               ack_ph;
		logic               nak;
		logic [5:0]         ref_sy;
		logic [8:0]         addr;
		logic [3:0]         wcnt;
		logic               sda_oe;
		logic [15:0]        twc;
		logic               busy;
		logic               drain;
		logic [8:0]         last;
	} ees_slave_s;
	ees_slave_s s_r;
	ees_slave_s s_nxt;
	logic [7:0]  mem [`EES_MEM_BYTES];
	logic [7:0]  rd_byte;
	logic [16:0] f_in;
	logic        f_valid;
	logic        f_ready;
	logic [16:0] f_out;
	logic        f_ovalid;
	assign rd_byte = mem[s_r.addr];
	assign busy    = s_r.busy;
	assign bus.sda_s_oe = s_r.sda_oe;
	// page bytes queue here and are committed only during the write cycle
	ees_fifo #(.WIDTH(17), .DEPTH(`EES_PAGE_BYTES)) u_wq (
		.clk_sys   (clk_sys),
		.rstn      (rstn),
		.in_valid  (f_valid),
		.in_ready  (f_ready),
		.in_data   (f_in),
		.out_valid (f_ovalid),
		.out_ready (s_r.drain),
		.out_data  (f_out)
	);
	always_ff @(posedge clk_sys) begin
		if (s_r.drain && f_ovalid)
			mem[f_out[16:8]] <= f_out[7:0];
	end
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;
	always_comb begin
		s_nxt    = s_r;
		f_valid  = 1'b0;
		f_in     = '0;
		s_nxt.scl_sy = {s_r.scl_sy[0], bus.scl};
		s_nxt.sda_sy = {s_r.sda_sy[0], bus.sda};
		s_nxt.ref_sy = {s_r.ref_sy[2:0], slave_address_reference};
		// a level must hold FILT_CYC cycles before it is believed
		if (s_r.scl_sy[1] == s_r.scl_f)
			s_nxt.scl_cnt = '0;
		else if (s_r.scl_cnt == 4'(FILT_CYC - 1)) begin
			s_nxt.scl_f   = s_r.scl_sy[1];
			s_nxt.scl_cnt = '0;
		end else
			s_nxt.scl_cnt = s_r.scl_cnt + 4'h1;
		if (s_r.sda_sy[1] == s_r.sda_f)
			s_nxt.sda_cnt = '0;
		else if (s_r.sda_cnt == 4'(FILT_CYC - 1)) begin
			s_nxt.sda_f   = s_r.sda_sy[1];
			s_nxt.sda_cnt = '0;
		end else
			s_nxt.sda_cnt = s_r.sda_cnt + 4'h1;
		scl_rise = s_nxt.scl_f && !s_r.scl_f;
		scl_fall = !s_nxt.scl_f && s_r.scl_f;
		start_c  = s_r.scl_f && s_nxt.scl_f && s_r.sda_f && !s_nxt.sda_f;
		stop_c   = s_r.scl_f && s_nxt.scl_f && !s_r.sda_f && s_nxt.sda_f;
		s_nxt.drain = 1'b0;
		if (s_r.busy) begin
			// write cycle: commit queue, bus inputs only watched for polling
			s_nxt.drain = f_ovalid;
			if (s_r.twc == 16'(TWC_CYC - 1))
				s_nxt.busy = 1'b0;
			else
				s_nxt.twc = s_r.twc + 16'h1;
		end
		if (start_c) begin
			s_nxt.st     = ees_pkg::ES_DEV;
			// the scl fall that closes the start is not a data bit
			s_nxt.bitn   = 4'hF;
			s_nxt.ack_ph = 1'b0;
			s_nxt.sda_oe = 1'b0;
		end else if (stop_c) begin
			if (s_r.st == ees_pkg::ES_WDAT && s_r.wcnt != 0 && !s_r.busy) begin
				s_nxt.busy = 1'b1;
				s_nxt.twc  = '0;
				// counter follows last written location within page
				s_nxt.addr = {s_r.last[8:3], s_r.last[2:0] + 3'h1};
			end
			s_nxt.st     = ees_pkg::ES_IDLE;
			s_nxt.sda_oe = 1'b0;
		end else if (s_r.st != ees_pkg::ES_IDLE && s_r.st != ees_pkg::ES_WAIT)
		begin
			if (scl_rise && !s_r.ack_ph)
				s_nxt.sh = {s_r.sh[6:0], s_r.sda_f};
			if (scl_rise && s_r.ack_ph && s_r.st == ees_pkg::ES_RACK)
				s_nxt.nak = s_r.sda_f;
			if (scl_fall) begin
				if (!s_r.ack_ph && s_r.bitn == 4'h7) begin
					s_nxt.ack_ph = 1'b1;
					s_nxt.bitn   = '0;
					s_nxt.sda_oe = 1'b0;
					case (s_r.st)
					ees_pkg::ES_DEV: begin
						if (s_r.sh[7:4] == `EES_DEV_CODE &&
							s_r.sh[3:1] == s_r.ref_sy[5:3]) begin
							// busy: answer 1 by leaving bus released
							s_nxt.sda_oe = !s_r.busy;
							if (s_r.busy || (s_r.sh[0] && s_r.busy))
								s_nxt.st = ees_pkg::ES_WAIT;
							else if (s_r.sh[0])
								s_nxt.st = ees_pkg::ES_RDAT;
							else
								s_nxt.st = ees_pkg::ES_AHI;
						end else
							s_nxt.st = ees_pkg::ES_IDLE;
					end
					ees_pkg::ES_AHI: begin
						s_nxt.addr[8] = s_r.sh[0];
						s_nxt.sda_oe  = 1'b1;
						s_nxt.st      = ees_pkg::ES_ALO;
					end
					ees_pkg::ES_ALO: begin
						s_nxt.addr[7:0] = s_r.sh;
						s_nxt.sda_oe    = 1'b1;
						s_nxt.wcnt      = '0;
						s_nxt.st        = ees_pkg::ES_WDAT;
					end
					ees_pkg::ES_WDAT: begin
						f_valid = f_ready;
						f_in    = {s_r.addr, s_r.sh};
						s_nxt.sda_oe = f_ready;
						if (f_ready) begin
							s_nxt.last = s_r.addr;
							s_nxt.wcnt = s_r.wcnt + 4'h1;
							s_nxt.addr = {s_r.addr[8:3], s_r.addr[2:0] + 3'h1};
						end
					end
					ees_pkg::ES_RDAT: begin
						s_nxt.st = ees_pkg::ES_RACK;
					end
					default: s_nxt.st = ees_pkg::ES_IDLE;
					endcase
				end else if (s_r.ack_ph) begin
					s_nxt.ack_ph = 1'b0;
					s_nxt.sda_oe = 1'b0;
					if (s_r.st == ees_pkg::ES_RACK) begin
						// a nacked byte still counts as accessed
						s_nxt.addr = s_r.addr + 9'h001;
						if (s_r.nak)
							s_nxt.st = ees_pkg::ES_WAIT;
						else
							s_nxt.st = ees_pkg::ES_RDAT;
					end
					if (s_nxt.st == ees_pkg::ES_RDAT) begin
						s_nxt.sda_oe = !rd_byte[7]; // msb first
						s_nxt.bitn   = 4'h0;
						if (s_r.st == ees_pkg::ES_RACK)
							s_nxt.sda_oe = !mem[s_r.addr + 9'h001][7];
					end
				end else begin
					s_nxt.bitn = s_r.bitn + 4'h1;
					if (s_r.st == ees_pkg::ES_RDAT)
						s_nxt.sda_oe = !rd_byte[3'(6 - s_r.bitn)];
				end
			end
			if (s_nxt.st == ees_pkg::ES_RACK && s_r.st == ees_pkg::ES_RDAT)
				s_nxt.addr = s_r.addr;
		end
	end
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			s_r        <= '0;
			s_r.scl_sy <= 2'h3;
			s_r.sda_sy <= 2'h3;
			s_r.scl_f  <= 1'b1;
			s_r.sda_f  <= 1'b1;
			s_r.st     <= ees_pkg::ES_IDLE;
		end else
			s_r <= s_nxt;
	end
endmodule
`default_nettype wire

// ===== hdl/ees_master.sv
// two-wire master: issues byte transfers to the eeprom
`include "ees_defs.svh"
`default_nettype none
module ees_master #(
	parameter int HALF_CYC = `EES_SCL_HALF_CYC
) (
	// clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  rstn,
	// command: start flag, byte, read/write, stop after
	input  wire logic                  cmd_valid,
	output logic                       cmd_ready,
	input  wire logic                  cmd_start,
	input  wire logic                  cmd_read,
	input  wire logic                  cmd_last,
	input  wire logic                  cmd_stop,
	input  wire logic [7:0]            cmd_data,
	// answer
	output logic                       rsp_valid,
	output logic [7:0]                 rsp_data,
	output logic                       rsp_nak,
	// link
	ees_if.master                      bus
);
	// shorter quarters would let the slave's filter lag eat the setup
	if (HALF_CYC < 4 || HALF_CYC > 255) begin : g_bad_half
		$error("bad scl half period");
	end
	typedef struct packed {
		ees_pkg::ees_mstate_e st;
		logic [7:0] div;
		logic [1:0] ph;
		logic [3:0] bitn;
		logic [7:0] sh;
		logic       rd;
		logic       last;
		logic       stop;
		logic       scl_o;
		logic       sda_oe;
		logic       rdy;
		logic       rv;
		logic [7:0] rdat;
		logic       nak;
		logic [1:0] sda_sy;
	} ees_master_s;
	ees_master_s m_r;
	ees_master_s m_nxt;
	logic tick;
	assign cmd_ready     = m_r.rdy;
	assign rsp_valid     = m_r.rv;
	assign rsp_data      = m_r.rdat;
	assign rsp_nak       = m_r.nak;
	assign bus.scl_o     = m_r.scl_o;
	assign bus.scl_oe    = 1'b1;
	assign bus.sda_m_oe  = m_r.sda_oe;
	always_comb begin
		m_nxt = m_r;
		m_nxt.rv = 1'b0;
		m_nxt.sda_sy = {m_r.sda_sy[0], bus.sda};
		tick = m_r.div == 8'(HALF_CYC - 1);
		m_nxt.div = tick ? 8'h00 : m_r.div + 8'h01;
		case (m_r.st)
		ees_pkg::MS_IDLE: begin
			m_nxt.rdy = 1'b1;
			if (cmd_valid && m_r.rdy) begin
				m_nxt.rdy  = 1'b0;
				m_nxt.sh   = cmd_data;
				m_nxt.rd   = cmd_read;
				m_nxt.last = cmd_last;
				m_nxt.stop = cmd_stop;
				m_nxt.ph   = '0;
				m_nxt.bitn = '0;
				m_nxt.st   = cmd_start ? ees_pkg::MS_START : ees_pkg::MS_BIT;
			end
		end
		ees_pkg::MS_START: if (tick) begin
			m_nxt.ph = m_r.ph + 2'h1;
			case (m_r.ph)
			2'h0: m_nxt.sda_oe = 1'b0;
			2'h1: m_nxt.scl_o  = 1'b1;
			2'h2: m_nxt.sda_oe = 1'b1;
			default: begin
				m_nxt.scl_o = 1'b0;
				m_nxt.st    = ees_pkg::MS_BIT;
				m_nxt.ph    = '0;
			end
			endcase
		end
		ees_pkg::MS_BIT: if (tick) begin
			m_nxt.ph = m_r.ph + 2'h1;
			case (m_r.ph)
			2'h0: m_nxt.sda_oe = m_r.rd ? 1'b0 : !m_r.sh[7];
			2'h1: m_nxt.scl_o  = 1'b1;
			2'h2: m_nxt.rdat   = {m_r.rdat[6:0], m_r.sda_sy[1]};
			default: begin
				m_nxt.scl_o = 1'b0;
				m_nxt.sh    = {m_r.sh[6:0], 1'b0};
				m_nxt.bitn  = m_r.bitn + 4'h1;
				m_nxt.ph    = '0;
				if (m_r.bitn == 4'h7)
					m_nxt.st = ees_pkg::MS_ACK;
			end
			endcase
		end
		ees_pkg::MS_ACK: if (tick) begin
			m_nxt.ph = m_r.ph + 2'h1;
			case (m_r.ph)
			// ack 0 to go on, release to end
			2'h0: m_nxt.sda_oe = m_r.rd && !m_r.last;
			2'h1: m_nxt.scl_o  = 1'b1;
			2'h2: m_nxt.nak    = m_r.sda_sy[1];
			default: begin
				m_nxt.scl_o  = 1'b0;
				m_nxt.ph     = '0;
				m_nxt.st     = m_r.stop ? ees_pkg::MS_STOP : ees_pkg::MS_DONE;
			end
			endcase
		end
		ees_pkg::MS_STOP: if (tick) begin
			m_nxt.ph = m_r.ph + 2'h1;
			case (m_r.ph)
			2'h0: m_nxt.sda_oe = 1'b1;
			2'h1: m_nxt.scl_o  = 1'b1;
			2'h2: m_nxt.sda_oe = 1'b0;
			default: m_nxt.st  = ees_pkg::MS_DONE;
			endcase
		end
		ees_pkg::MS_DONE: begin
			if (m_r.rd)
				m_nxt.nak = 1'b0;
			m_nxt.rv = 1'b1;
			m_nxt.st = ees_pkg::MS_IDLE;
		end
		default: m_nxt.st = ees_pkg::MS_IDLE;
		endcase
	end
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			m_r        <= '0;
			m_r.scl_o  <= 1'b1;
			m_r.sda_sy <= 2'h3;
			m_r.st     <= ees_pkg::MS_IDLE;
		end else
			m_r <= m_nxt;
	end
endmodule
`default_nettype wire

// ===== dv/ees_link_checker.sv
// assertions on the two-wire link between the master and the eeprom slave
`include "ees_defs.svh"
`default_nettype none
module ees_link_checker #(
	parameter int TWC_CYC = `EES_TWC_CYC
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// link wires and slave status
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_s_oe,
	input wire logic busy
);
	localparam int TWC_LO = TWC_CYC - 2;
	typedef struct packed {
		logic [3:0] bit_n;
		logic       rd;
		logic       first;
		logic       scl_q;
		logic       sda_q;
	} ees_chk_s;
	ees_chk_s st_r;
	ees_chk_s st_nxt;
	logic     rise;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);
	assign rise = scl && !st_r.scl_q;
	// bit position inside each byte, counted from the last start
	always_comb begin
		st_nxt = st_r;
		st_nxt.scl_q = scl;
		st_nxt.sda_q = sda;
		if (scl && st_r.scl_q && st_r.sda_q && !sda) begin
			st_nxt.bit_n = 4'h0;
			st_nxt.first = 1'b1;
		end else if (rise) begin
			st_nxt.bit_n = (st_r.bit_n == 4'h8) ? 4'h0 : st_r.bit_n + 4'h1;
			if (st_r.first && st_r.bit_n == 4'h7) begin
				st_nxt.rd = sda;
			end
			if (st_r.bit_n == 4'h8) begin
				st_nxt.first = 1'b0;
			end
		end
	end
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			st_r <= ees_chk_s'(8'h03);
		end else begin
			st_r <= st_nxt;
		end
	end
	a_slave_moves_low: assert property (
		!$stable(sda_s_oe) |-> !scl && !$past(scl))
		else $error("slave sda changed with scl high");
	a_bit_hold: assert property (
		$rose(scl) |=> $stable(sda) [*2])
		else $error("sda moved just after scl rose");
	a_busy_no_ack: assert property (
		busy |-> !sda_s_oe)
		else $error("slave pulled sda while busy");
	a_write_after_stop: assert property (
		$rose(busy) |-> scl && sda)
		else $error("write cycle began without a stop");
	a_write_cycle_len: assert property (
		$rose(busy) |-> (busy throughout (##TWC_LO 1)) ##[1:4] !busy)
		else $error("write cycle length wrong");
	a_stop_release: assert property (
		scl && $rose(sda) |=> !sda_s_oe [*8])
		else $error("slave drove sda after stop");
	a_write_ack_slot: assert property (
		rise && sda_s_oe && (!st_r.rd || st_r.first) |-> st_r.bit_n == 4'h8)
		else $error("slave pulled sda outside ack bit");
	a_ack_slot_free: assert property (
		rise && st_r.rd && !st_r.first && st_r.bit_n == 4'h8 |-> !sda_s_oe)
		else $error("slave drove the master ack bit");
endmodule
`default_nettype wire

// ===== dv/tb_i2c_serial_eeprom_slave.sv
// self-checking bench: eeprom slave and master joined over the link
`include "ees_defs.svh"
`default_nettype none
module tb_i2c_serial_eeprom_slave;
	timeunit 1ns;
	timeprecision 100ps;
	// long write cycle so the first poll always lands while busy
	localparam int         TWC   = 250;
	localparam logic [2:0] STRAP = 3'h5;
	localparam logic [7:0] DEV_W = {`EES_DEV_CODE, STRAP, 1'b0};
	localparam logic [7:0] DEV_R = DEV_W | 8'h01;
	logic       clk_sys   = 1'b0;
	logic       rstn      = 1'b0;
	logic       cmd_valid = 1'b0;
	logic       cmd_start = 1'b0;
	logic       cmd_read  = 1'b0;
	logic       cmd_last  = 1'b0;
	logic       cmd_stop  = 1'b0;
	logic [7:0] cmd_data  = 8'h00;
	logic       cmd_ready;
	logic       rsp_valid;
	logic [7:0] rsp_data;
	logic       rsp_nak;
	logic       busy;
	logic [7:0] q;
	logic       nak;
	logic [7:0] mem [512];
	int         bad_count  = 0;
	int         n_compared = 0;
	ees_if bus_if ();
	ees_slave #(.FILT_CYC(2), .TWC_CYC(TWC)) u_ees_slave (
		.clk_sys(clk_sys), .rstn(rstn), .slave_address_reference(STRAP),
		.busy(busy), .bus(bus_if));
	ees_master #(.HALF_CYC(4)) u_ees_master (
		.clk_sys(clk_sys), .rstn(rstn), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_start(cmd_start), .cmd_read(cmd_read),
		.cmd_last(cmd_last), .cmd_stop(cmd_stop), .cmd_data(cmd_data),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nak(rsp_nak),
		.bus(bus_if));
	ees_link_checker #(.TWC_CYC(TWC)) u_ees_link_checker (
		.clk_sys(clk_sys), .rstn(rstn), .scl(bus_if.scl),
		.sda(bus_if.sda), .sda_s_oe(bus_if.sda_s_oe), .busy(busy));
	always #12.5 clk_sys = ~clk_sys;
	task automatic complete_run();
		$display("compared %0d, wrong %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	endtask
	// one byte through the master; reads that stop also get the nack
	task automatic xfer(input logic s, input logic rdb, input logic stp,
		input logic [7:0] d);
		int i;
		@(posedge clk_sys);
		cmd_valid <= 1'b1;
		cmd_start <= s;
		cmd_read  <= rdb;
		cmd_last  <= rdb && stp;
		cmd_stop  <= stp;
		cmd_data  <= d;
		do @(posedge clk_sys); while (cmd_ready !== 1'b1);
		cmd_valid <= 1'b0;
		for (i = 0; i < 4000 && rsp_valid !== 1'b1; i++) @(posedge clk_sys);
		if (i == 4000) bad_count++;
		q   = rsp_data;
		nak = rsp_nak;
	endtask
	task automatic wr(input logic s, input logic stp, input logic [7:0] d,
		input logic exp_nak);
		xfer(s, 1'b0, stp, d);
		check({7'h0, nak}, {7'h0, exp_nak});
	endtask
	task automatic set_addr(input logic [7:0] hi, input logic [7:0] lo);
		wr(1'b1, 1'b0, DEV_W, 1'b0);
		wr(1'b0, 1'b0, hi, 1'b0);
		wr(1'b0, 1'b0, lo, 1'b0);
	endtask
	task automatic poll();
		int k;
		xfer(1'b1, 1'b0, 1'b1, DEV_W);
		check({7'h0, nak}, 8'h01);
		for (k = 0; k < 20 && nak !== 1'b0; k++) begin
			xfer(1'b1, 1'b0, 1'b1, DEV_W);
		end
		check({7'h0, nak}, 8'h00);
	endtask
	task automatic page(input logic [8:0] a, input int n,
		input logic [7:0] base);
		set_addr({7'h0, a[8]}, a[7:0]);
		for (int i = 0; i < n; i++) begin
			wr(1'b0, i == n - 1, base + 8'(i), 1'b0);
			mem[{a[8:3], a[2:0] + 3'(i)}] = base + 8'(i);
		end
		poll();
	endtask
	task automatic rd_seq(input logic [8:0] a, input int n);
		wr(1'b1, 1'b0, DEV_R, 1'b0);
		for (int i = 0; i < n; i++) begin
			xfer(1'b0, 1'b1, i == n - 1, 8'hFF);
			check(q, mem[a]);
			a = a + 9'h1;
		end
	endtask
	initial begin
		repeat (60000) @(posedge clk_sys);
		bad_count++;
		complete_run();
	end
	initial begin
		repeat (8) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (2) @(posedge clk_sys);
		// foreign device code, then own code with other strap bits
		xfer(1'b1, 1'b0, 1'b1, DEV_W ^ 8'h80);
		check({7'h0, nak}, 8'h01);
		xfer(1'b1, 1'b0, 1'b1, DEV_W ^ 8'h04);
		check({7'h0, nak}, 8'h01);
		page(9'h000, 1, 8'h5A);
		page(9'h1FE, 8, 8'h30);
		rd_seq(9'h1FE, 3);
		page(9'h108, 8, 8'h40);
		rd_seq(9'h108, 1);
		// upper bits of the high address byte must be dropped
		set_addr(8'hFF, 8'hF9);
		rd_seq(9'h1F9, 2);
		// counter moves past a nacked byte too
		rd_seq(9'h1FB, 1);
		complete_run();
	end
endmodule
`default_nettype wire
